//--- hw/pfs_pkg.sv
// Shared constants and types of the program flash sequencer.
// Assumes a 100 MHz system clock and an APB slave port with 16-bit addresses.
package pfs_pkg;
   // Array geometry
   localparam int unsigned PAGES       = 384;
   localparam int unsigned PAGE_WORDS  = 64;
   localparam int unsigned ROW_WORDS   = 32;
   localparam int unsigned FLASH_WORDS = PAGES * PAGE_WORDS;
   localparam int unsigned FLASH_AW    = 15;
   localparam int unsigned DATA_W      = 16;
   localparam logic [15:0] FLASH_TOP   = 16'hBFFF;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   // Register byte offsets
   localparam logic [15:0] OFF_CSR     = 16'hF000;
   localparam logic [15:0] OFF_PRESC   = 16'hF004;
   localparam logic [15:0] OFF_KEY     = 16'hF008;
   localparam logic [15:0] OFF_MODULE_STATUS_REG   = 16'hF00C;
   localparam logic [15:0] OFF_BUSCFG  = 16'hF010;
   // Control/status field positions
   localparam int unsigned CSR_ERASE   = 1;
   localparam int unsigned CSR_BUSY    = 2;
   localparam int unsigned CSR_FULL    = 3;
   localparam int unsigned CSR_IEN     = 4;
   localparam int unsigned MST_BUSY    = 0;
   localparam int unsigned MST_MODE    = 1;
   localparam int unsigned CFG_WAIT    = 0;
   // Key and reset values
   localparam logic [7:0]  KEY_VAL     = 8'hA3;
   localparam logic [7:0]  KEY_READ    = 8'hFF;
   localparam logic [7:0]  PRESC_RST   = 8'h33;
   // Timing: pulse widths in program/erase clock ticks
   localparam int unsigned CLK_KHZ       = 100000;
   localparam int unsigned NOWAIT_KHZ    = 12500;
   localparam logic        WAIT_RST      = 1'(CLK_KHZ > NOWAIT_KHZ);
   localparam int unsigned PE_CLK_KHZ    = 200;
   localparam int unsigned ERASE_US      = 1000;
   localparam int unsigned PROG_US       = 30;
   localparam int unsigned ERASE_TICKS_D = ERASE_US * PE_CLK_KHZ / 1000;
   localparam int unsigned PROG_TICKS_D  = PROG_US * PE_CLK_KHZ / 1000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_ERASE = 3'h1,
      ST_FILL  = 3'h2,
      ST_PROG  = 3'h3,
      ST_ABORT = 3'h4
   } pfs_state_t;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_ISP    = 2'h1,
      MODE_TEST   = 2'h2,
      MODE_RSVD   = 2'h3
   } pfs_mode_t;
endpackage

//--- hw/pfs_presc.sv
// Program/erase clock prescaler: one-cycle tick every div+1 clocks.
// Assumes restart is held while no operation runs, so timing starts clean.
module pfs_presc #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Control
   input  wire logic         restart,
   input  wire logic [W-1:0] div,
   // Tick out
   output logic              tick
);
   logic [W-1:0] cnt_r;

   // Count 0..div, pulse on wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (restart) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (cnt_r == div) begin
         cnt_r <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule

//--- hw/pfs_mem.sv
// Flash array model: one write port, one registered read port.
// Assumes the sequencer never reads and writes the same word in one cycle.
module pfs_mem #(
   parameter int unsigned DEPTH = 24576,
   parameter int unsigned AW    = 15,
   parameter int unsigned DW    = 16
) (
   // Clock
   input  wire logic          pclk,
   // Write port
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   // Read port
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [DEPTH];

   // Contents are not reset: a real array keeps them over reset
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

//--- hw/pfs_top.sv
// Program flash sequencer: APB reads, keyed erase and row programming.
// Assumes the CPU is the APB master and reset pins come in synchronously.

// Notes on behaviour
// - Plain stores into flash range leave contents unchanged.
// - Boot mode taken from two mode pins at reset release.
// - 384 pages of 64 words, each page two rows of 32.
// - Busy rises when erase or programming begins, falls when done.
// - Whole flash refuses reads while busy.
// - Each erase or program write needs the key written just before.
// - With erase bit set, keyed write erases its whole page.
// - Erased page reads back all ones.
// - Erase pulse lasts 1 ms in program clock ticks.
// - Each programmed word gets a 30 us interval.
// - Keyed word when idle starts programming; whole words only.
// - One more word buffered during programming; buffer-full flag set.
// - Word done: address increments, buffered word starts, flag clears.
// - Running past row end starts a fresh pulse automatically.
// - Last word done: buffer flag clear, busy falls.
// - Reset request aborts operation and holds reset until idle.
// - Program clock is clock over prescaler; fixed during operation.
// - Reads run zero-wait up to 12.5 MHz, else one wait.
// - Key register arms on A3, reads back FF.
// - Prescaler divides by value plus one, resets to 33 hex.
// - Interrupt pulse when buffer-full falls as the buffered word starts, if enabled; an abort clears it with no pulse.
module pfs_top
   import pfs_pkg::*;
#(
   parameter int unsigned ERASE_TICKS = ERASE_TICKS_D,
   parameter int unsigned PROG_TICKS  = PROG_TICKS_D
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Mode pins and reset handshake
   input  wire logic        boot_mode_select_low_n,
   input  wire logic        boot_mode_select_high_n,
   input  wire logic        sys_reset_req,
   output logic             sys_reset_hold,
   output logic [1:0]       boot_mode,
   // Status outputs
   output logic             flash_op_active,
   output logic             write_buffer_full,
   output logic             buf_drain_irq,
   output logic             hv_pulse
);
   pfs_state_t           state_r, state_nxt;
   logic                 key_armed_r, erase_r, irq_en_r, one_wait_r;
   logic                 buf_full_r, pready_r, pslverr_r, wr_ok_r, wcnt_r;
   logic                 op_active_r, irq_r, hv_r, hold_r, mode_cap_r;
   logic [7:0]           presc_r;
   logic [31:0]          prdata_r, rd_val;
   logic [1:0]           mode_r;
   logic [FLASH_AW-1:0]  cur_addr_r, mem_waddr;
   logic [DATA_W-1:0]    cur_data_r, buf_data_r, mem_wdata, mem_rdata;
   logic [15:0]          tcnt_r;
   logic [5:0]           fill_r;
   logic                 tick, mem_we, access, done, wr, fsel, idle;
   logic                 fw_ok, fw_take, prog_end, advance, reg_hit;

   // Flash window decode, used for reads, writes and checks
   function automatic logic is_flash(input logic [15:0] a);
      return a <= FLASH_TOP;
   endfunction

   // APB phases; a write acts only at the edge that completes it
   assign access  = psel & penable & ~pready_r;
   assign done    = psel & penable & pready_r;
   assign wr      = done & pwrite;
   assign fsel    = is_flash(paddr);
   assign idle    = (state_r == ST_IDLE);
   assign fw_take = wr & fsel & wr_ok_r;
   assign reg_hit = (paddr == OFF_CSR) | (paddr == OFF_PRESC) |
                    (paddr == OFF_KEY) | (paddr == OFF_MODULE_STATUS_REG) |
                    (paddr == OFF_BUSCFG);

   // Keyed full-word write into a free slot; byte stores never program
   assign fw_ok = key_armed_r & (pstrb[1:0] == 2'b11) & ~paddr[0] &
                  (idle | (state_r == ST_PROG & ~buf_full_r & ~erase_r));

   // Word interval ends on the last tick of the programming slot
   assign prog_end = (state_r == ST_PROG) & tick &
                     (tcnt_r == 16'(PROG_TICKS - 1));
   // A word is ready to follow: buffered, or landing right now
   assign advance  = prog_end & (buf_full_r | fw_take);

   // Register read mux; reserved bits read as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         OFF_CSR: begin
            rd_val[CSR_ERASE] = erase_r;
            rd_val[CSR_BUSY]  = op_active_r;
            rd_val[CSR_FULL]  = buf_full_r;
            rd_val[CSR_IEN]   = irq_en_r;
         end
         OFF_PRESC:  rd_val[7:0] = presc_r;
         OFF_KEY:    rd_val[7:0] = KEY_READ;
         OFF_MODULE_STATUS_REG: begin
            rd_val[MST_BUSY]            = op_active_r;
            rd_val[MST_MODE+1:MST_MODE] = mode_r;
         end
         OFF_BUSCFG: rd_val[CFG_WAIT] = one_wait_r;
         default:    rd_val = 32'h0000_0000;
      endcase
   end

   // APB answer: registers answer after one access cycle, flash reads
   // after one more when the wait state is on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         wcnt_r    <= 1'b0;
         wr_ok_r   <= 1'b0;
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         wr_ok_r   <= 1'b0;
         if (access) begin
            if (fsel & ~pwrite & ~idle) begin
               pready_r  <= 1'b1;
               pslverr_r <= 1'b1;
               prdata_r  <= 32'h0000_0000;
            end else if (fsel & ~pwrite) begin
               if (wcnt_r == one_wait_r) begin
                  pready_r <= 1'b1;
                  prdata_r <= {16'h0000, mem_rdata};
                  wcnt_r   <= 1'b0;
               end else begin
                  wcnt_r <= 1'b1;
               end
            end else if (fsel) begin
               // Unkeyed stores end in an error and touch nothing
               pready_r  <= 1'b1;
               pslverr_r <= ~fw_ok;
               wr_ok_r   <= fw_ok;
            end else begin
               pready_r  <= 1'b1;
               pslverr_r <= ~reg_hit;
               prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
            end
         end
      end
   end

   // Control bits; prescaler is frozen while an operation runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_r    <= 1'b0;
         irq_en_r   <= 1'b0;
         one_wait_r <= WAIT_RST;
         presc_r    <= PRESC_RST;
      end else if (wr) begin
         if (paddr == OFF_CSR) begin
            erase_r  <= pwdata[CSR_ERASE];
            irq_en_r <= pwdata[CSR_IEN];
         end
         if (paddr == OFF_PRESC && idle) begin
            presc_r <= pwdata[7:0];
         end
         if (paddr == OFF_BUSCFG) begin
            one_wait_r <= pwdata[CFG_WAIT];
         end
      end
   end

   // Unlock key: any completed write re-decides the armed state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_armed_r <= 1'b0;
      end else if (wr) begin
         key_armed_r <= (paddr == OFF_KEY) &
                        (pwdata[7:0] == KEY_VAL);
      end
   end

   // Mode pins caught on the first edge after release, not in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_cap_r <= 1'b0;
         mode_r     <= MODE_NORMAL;
      end else if (!mode_cap_r) begin
         mode_cap_r <= 1'b1;
         mode_r     <= {~boot_mode_select_high_n,
                        ~boot_mode_select_low_n};
      end
   end

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (fw_take & ~sys_reset_req) begin
               state_nxt = erase_r ? ST_ERASE : ST_PROG;
            end
         end
         ST_ERASE: begin
            if (tick && tcnt_r == 16'(ERASE_TICKS - 1)) begin
               state_nxt = ST_FILL;
            end
         end
         ST_FILL: begin
            if (fill_r == 6'(PAGE_WORDS - 1)) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_PROG: begin
            if (prog_end & ~advance) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_ABORT: begin
            if (tick) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // Reset request cuts any running operation short
      if (sys_reset_req && !idle && state_r != ST_ABORT) begin
         state_nxt = ST_ABORT;
      end
   end

   // State and the flopped status outputs derived from it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= ST_IDLE;
         op_active_r <= 1'b0;
         hold_r      <= 1'b0;
         hv_r        <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         op_active_r <= (state_nxt != ST_IDLE);
         hold_r      <= sys_reset_req | (state_nxt == ST_ABORT);
         // Row crossing drops the pulse for a cycle to start a new one
         hv_r <= ((state_nxt == ST_ERASE) | (state_nxt == ST_PROG)) &
                 ~(advance & (cur_addr_r[4:0] == 5'(ROW_WORDS - 1)));
      end
   end

   // Working word, address and pulse counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_addr_r <= '0;
         cur_data_r <= 16'h0000;
         tcnt_r     <= 16'h0000;
         fill_r     <= 6'h00;
      end else if (idle) begin
         if (fw_take) begin
            cur_addr_r <= paddr[FLASH_AW:1];
            cur_data_r <= pwdata[DATA_W-1:0];
         end
         tcnt_r <= 16'h0000;
         fill_r <= 6'h00;
      end else if (state_r == ST_FILL) begin
         fill_r <= fill_r + 6'h01;
      end else if (advance) begin
         // Next word goes to the next address whatever it was sent to
         cur_addr_r <= cur_addr_r + 1'b1;
         cur_data_r <= buf_full_r ? buf_data_r : pwdata[DATA_W-1:0];
         tcnt_r     <= 16'h0000;
      end else if (tick) begin
         tcnt_r <= tcnt_r + 16'h0001;
      end
   end

   // Second buffer stage and drain interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_full_r <= 1'b0;
         buf_data_r <= 16'h0000;
         irq_r      <= 1'b0;
      end else begin
         irq_r <= 1'b0;
         if (state_r == ST_ABORT) begin
            buf_full_r <= 1'b0;
         end else if (advance & buf_full_r) begin
            buf_full_r <= 1'b0;
            irq_r      <= irq_en_r;
         end else if (fw_take && state_r == ST_PROG && !prog_end) begin
            buf_full_r <= 1'b1;
            buf_data_r <= pwdata[DATA_W-1:0];
         end
      end
   end

   // Array write: erase fills the page with ones, page from address
   assign mem_we    = (state_r == ST_FILL) | (prog_end & ~sys_reset_req);
   assign mem_waddr = (state_r == ST_FILL) ?
                      {cur_addr_r[FLASH_AW-1:6], fill_r} : cur_addr_r;
   assign mem_wdata = (state_r == ST_FILL) ? ERASED_WORD : cur_data_r;

   pfs_mem #(
      .DEPTH (FLASH_WORDS),
      .AW    (FLASH_AW),
      .DW    (DATA_W)
   ) u_mem (
      .pclk  (pclk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (paddr[FLASH_AW:1]),
      .rdata (mem_rdata)
   );

   // Prescaler held at zero while idle so every pulse times from start
   pfs_presc #(
      .W (8)
   ) u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (idle),
      .div     (presc_r),
      .tick    (tick)
   );

   assign pready            = pready_r;
   assign pslverr           = pslverr_r;
   assign prdata            = prdata_r;
   assign flash_op_active   = op_active_r;
   assign write_buffer_full = buf_full_r;
   assign buf_drain_irq     = irq_r;
   assign hv_pulse          = hv_r;
   assign sys_reset_hold    = hold_r;
   assign boot_mode         = mode_r;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_busy_start;
      idle && fw_take && !sys_reset_req |=> flash_op_active;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("busy did not rise at operation start");

   property p_unkeyed;
      idle && wr && fsel && !key_armed_r |=> idle;
   endproperty
   a_unkeyed: assert property (p_unkeyed)
      else $error("unkeyed flash write started an operation");

   property p_read_busy;
      pready && !pwrite && fsel && !idle |-> pslverr;
   endproperty
   a_read_busy: assert property (p_read_busy)
      else $error("flash read served while busy");

   property p_erase_ones;
      mem_we && state_r == ST_FILL |-> mem_wdata == 16'hFFFF;
   endproperty
   a_erase_ones: assert property (p_erase_ones)
      else $error("erase wrote a word other than all ones");

   property p_buf_set;
      fw_take && state_r == ST_PROG && !prog_end |=> write_buffer_full;
   endproperty
   a_buf_set: assert property (p_buf_set)
      else $error("second word did not set buffer full");

   property p_prog_slot;
      mem_we && state_r == ST_PROG |-> tick && tcnt_r == 16'(PROG_TICKS-1);
   endproperty
   a_prog_slot: assert property (p_prog_slot)
      else $error("word written outside its interval end");

   property p_key_read;
      pready && !pwrite && paddr == OFF_KEY |-> prdata == 32'h0000_00FF;
   endproperty
   a_key_read: assert property (p_key_read)
      else $error("key register read not FF");

   property p_drain_irq;
      $fell(write_buffer_full) && $past(state_r) != ST_ABORT &&
         $past(irq_en_r) |-> buf_drain_irq;
   endproperty
   a_drain_irq: assert property (p_drain_irq)
      else $error("no interrupt on buffer drain");

   property p_hold;
      // Held on the next cycle, and on the cycle after unless the array is idle by then
      sys_reset_req && !idle |=>
         sys_reset_hold ##1 (sys_reset_hold || idle);
   endproperty
   a_hold: assert property (p_hold)
      else $error("reset not held during abort");

   property p_disarm;
      wr && paddr != OFF_KEY |=> !key_armed_r;
   endproperty
   a_disarm: assert property (p_disarm)
      else $error("key stayed armed after another write");

   c_erase: cover property (state_r == ST_FILL ##1 idle);
   c_buffered: cover property (advance && buf_full_r);
   c_row_cross: cover property (advance && cur_addr_r[4:0] == 5'h1F);
   c_abort: cover property (state_r == ST_ABORT);
endmodule

//--- sim/pfs_cpu.sv
// CPU side model: APB master issuing loads, stores and control writes.
// Assumes the slave ends each access with a one-cycle pready pulse.
module pfs_cpu
   import pfs_pkg::*;
(
   // Clock
   input  wire logic        pclk,
   // Request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [15:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   // Answer
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle from time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 16'h0000;
      pwdata  = 32'h0000_0000;
      pstrb   = 4'hF;
   end
   // One transfer, held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; the bench watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

//--- sim/tb_top.sv
// Bench top: CPU model, sequencer and self-checking scenarios.
// Assumes short pulse counts and a prescaler of 3 to keep runs brief.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pfs_pkg::*;
   localparam logic [15:0] PB = 16'h0280; // Byte base of page 5
   localparam logic [31:0] K  = {24'h0, KEY_VAL};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [1:0]  boot_mode;
   logic        rst_req, rst_hold, busy, full, irq, hv;
   int          failures, comparisons, cyc;

   pfs_cpu cpu (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr));
   pfs_top #(.ERASE_TICKS(4), .PROG_TICKS(6)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .boot_mode_select_low_n(1'b0), .boot_mode_select_high_n(1'b1),
      .sys_reset_req(rst_req), .sys_reset_hold(rst_hold),
      .boot_mode(boot_mode), .flash_op_active(busy),
      .write_buffer_full(full), .buf_drain_irq(irq), .hv_pulse(hv));

   // 100 MHz clock and a cycle count for timing checks
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Access; reads compare data, both compare the error answer
   task automatic acc(logic w, logic [15:0] a, logic [31:0] d,
                      logic ee, string nm);
      logic [31:0] q;
      logic e;
      cpu.xfer(w, a, d, q, e);
      chk({nm, " err"}, {31'h0, e}, {31'h0, ee});
      if (!w) chk(nm, q, d);
   endtask
   task automatic kw;
      acc(1, OFF_KEY, K, 0, "key");
   endtask
   // Waits for busy low; a hang counts as a mismatch
   task automatic idle(output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (busy !== 1'b0 && n < 3000);
      if (n >= 3000) chk("idle", 32'h0, 32'h1);
   endtask

   task automatic t_regs;
      acc(0, OFF_PRESC, 32'h33, 0, "presc");
      acc(0, OFF_KEY, 32'hFF, 0, "key rd");
      acc(0, OFF_CSR, 32'h0, 0, "csr");
      acc(0, OFF_MODULE_STATUS_REG, 32'h2, 0, "module_status_reg");
      chk("mode", {30'h0, boot_mode}, 32'h1);
      acc(1, 16'hF0F0, 32'h0, 1, "unmapped");
      acc(1, OFF_PRESC, 32'h3, 0, "presc wr");
      acc(0, OFF_PRESC, 32'h3, 0, "presc rd");
   endtask
   task automatic t_erase;
      int t0;
      int n;
      acc(1, OFF_CSR, 32'h2, 0, "erase on");
      kw();
      acc(1, PB + 16'h7E, 32'h0, 0, "erase");
      t0 = cyc;
      @(posedge pclk);
      chk("busy", {31'h0, busy}, 32'h1);
      acc(0, 16'h0000, 32'h0, 1, "rd busy");
      idle(n);
      chk("erase time", {31'h0, (cyc - t0 >= 80)}, 32'h1);
      acc(1, OFF_CSR, 32'h0, 0, "erase off");
      acc(0, PB, 32'hFFFF, 0, "erased lo");
      acc(0, PB + 16'h7E, 32'hFFFF, 0, "erased hi");
   endtask
   task automatic t_plain;
      acc(1, PB + 16'h2, 32'h1234, 1, "no key");
      kw();
      acc(1, OFF_CSR, 32'h0, 0, "between");
      acc(1, PB + 16'h2, 32'h1234, 1, "disarmed");
      kw();
      acc(1, PB + 16'h3, 32'h1234, 1, "odd");
      acc(0, PB + 16'h2, 32'hFFFF, 0, "kept");
   endtask
   // Three words across a row end, one refused while full
   task automatic t_prog;
      int t0;
      int n;
      logic s;
      acc(1, OFF_CSR, 32'h10, 0, "irq en");
      kw();
      acc(1, PB + 16'h3C, 32'hA5A0, 0, "w0");
      t0 = cyc;
      kw();
      acc(1, PB + 16'h3E, 32'hA5A1, 0, "w1");
      @(posedge pclk);
      chk("full", {31'h0, full}, 32'h1);
      kw();
      acc(1, PB + 16'h40, 32'hA5A2, 1, "w full");
      s = 1'b0;
      n = 0;
      while (full !== 1'b0 && n < 200) begin
         @(posedge pclk);
         s |= irq;
         n++;
      end
      repeat (2) begin
         @(posedge pclk);
         s |= irq;
      end
      chk("irq", {31'h0, s}, 32'h1);
      chk("full clr", {31'h0, full}, 32'h0);
      chk("hv kept", {31'h0, hv}, 32'h1);
      kw();
      acc(1, PB + 16'h40, 32'hA5A2, 0, "w2");
      // Row end: the pulse drops for one cycle, then a new one starts
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (full !== 1'b0 && n < 200);
      chk("hv cross", {31'h0, hv}, 32'h0);
      chk("irq 2", {31'h0, irq}, 32'h1);
      @(posedge pclk);
      chk("hv new", {31'h0, hv}, 32'h1);
      idle(n);
      chk("prog time", {31'h0, (cyc - t0 >= 72)}, 32'h1);
      chk("full end", {31'h0, full}, 32'h0);
      acc(0, PB + 16'h3C, 32'hA5A0, 0, "rb0");
      acc(0, PB + 16'h3E, 32'hA5A1, 0, "rb1");
      acc(0, PB + 16'h40, 32'hA5A2, 0, "rb2");
      // Read latency in both wait settings, counted from the call
      acc(1, OFF_BUSCFG, 32'h0, 0, "zero wait");
      t0 = cyc;
      acc(0, PB + 16'h3C, 32'hA5A0, 0, "rb0 fast");
      chk("fast read", cyc - t0, 32'h4);
      acc(1, OFF_BUSCFG, 32'h1, 0, "one wait");
      t0 = cyc;
      acc(0, PB + 16'h3E, 32'hA5A1, 0, "rb1 slow");
      chk("slow read", cyc - t0, 32'h5);
      acc(0, OFF_BUSCFG, 32'h1, 0, "buscfg");
   endtask
   task automatic t_abort;
      logic [31:0] q;
      logic e;
      int n;
      acc(1, OFF_CSR, 32'h2, 0, "erase on");
      kw();
      acc(1, PB + 16'h80, 32'h0, 0, "erase 2");
      cpu.xfer(1, OFF_PRESC, 32'h10, q, e);
      rst_req <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("hold", {31'h0, rst_hold}, 32'h1);
      rst_req <= 1'b0;
      idle(n);
      chk("abort", {31'h0, (n < 40)}, 32'h1);
      repeat (2) @(posedge pclk);
      chk("hold off", {31'h0, rst_hold}, 32'h0);
      acc(0, OFF_PRESC, 32'h3, 0, "presc kept");
      acc(1, OFF_CSR, 32'h0, 0, "erase off");
   endtask

   task automatic end_of_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Reset for 8 cycles, then the scenarios in order
   initial begin
      failures = 0;
      comparisons = 0;
      cyc = 0;
      presetn = 1'b0;
      rst_req = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_erase();
      t_plain();
      t_prog();
      t_abort();
      end_of_test();
   end
   // Watchdog far beyond the expected run of about 330 cycles
   initial begin
      #200us;
      failures++;
      end_of_test();
   end
endmodule
